// [core/dee_top.sv]
// Data byte store access control with AXI4-Lite register interface
//
// Behaviour
// - A data-memory read puts the addressed byte in the data register next cycle.
// - The data register holds the read byte until another read or a write.
// - Programming starts only after 55h then AAh to unlock, then start bit.
// - The program start bit cannot be set while update permit is clear.
// - Hardware never clears the update permit bit; only software changes it.
// - A started program cycle completes even if update permit is cleared.
// - At program end the start bit clears and done flag sets together.
// - The done flag stays set until software clears it.
// - A reset that cuts a program cycle short sets the abort flag.
// - Space select zero routes accesses to data memory; with one, reads and starts are dropped.
`default_nettype none
`include "dee_consts.svh"

module dee_top
    import dee_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = `DEE_PROG_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic por_n,
    input wire logic [`DEE_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`DEE_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ------------------------------------------------------------------------
    // Bus front end
    // ------------------------------------------------------------------------
    dee_reg_wr_t reg_wr;
    logic reg_wr_en, reg_rd_en, reg_wr_err, reg_rd_err;
    logic [`DEE_ADDR_W-1:0] reg_rd_addr;
    logic [31:0] reg_rd_data;
    dee_sel_t wsel, rsel;
    logic we;
    logic [7:0] wb;

    dee_axil_slave u_bus (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .reg_wr(reg_wr),
        .reg_wr_en(reg_wr_en),
        .reg_wr_err(reg_wr_err),
        .reg_rd_en(reg_rd_en),
        .reg_rd_addr(reg_rd_addr),
        .reg_rd_data(reg_rd_data),
        .reg_rd_err(reg_rd_err)
    );

    assign wsel = dee_decode(reg_wr.addr);
    assign rsel = dee_decode(reg_rd_addr);
    assign reg_wr_err = (wsel == DEE_SEL_NONE);
    assign reg_rd_err = (rsel == DEE_SEL_NONE);
    // Registers are one byte wide; lane 0 carries them, other lanes are ignored
    assign we = reg_wr_en && reg_wr.strb[0] && !reg_wr_err;
    assign wb = reg_wr.data[7:0];

    // ------------------------------------------------------------------------
    // Byte store
    // ------------------------------------------------------------------------
    logic prog_start, arr_busy, arr_done;
    logic [7:0] arr_rdata;
    logic mss_q, mss_d, permit_q, permit_d, wr_q, wr_d, rd_q, rd_d;
    logic done_q, done_d, abort_q, abort_d;
    logic [7:0] data_q, data_d, addr_q, addr_d;
    dee_unlock_t ul_q, ul_d;

    dee_cell_array #(
        .PROG_CYCLES(PROG_CYCLES)
    ) u_array (
        .aclk(aclk),
        .aresetn(aresetn),
        .prog_start(prog_start),
        .prog_req('{addr: addr_q, data: data_q}),
        .rd_addr(addr_q),
        .rd_data(arr_rdata),
        .busy(arr_busy),
        .done(arr_done)
    );

    // ------------------------------------------------------------------------
    // Control state
    // ------------------------------------------------------------------------
    always_comb begin
        mss_d = mss_q;
        permit_d = permit_q;
        wr_d = wr_q;
        rd_d = rd_q;
        done_d = done_q;
        data_d = data_q;
        addr_d = addr_q;
        ul_d = ul_q;
        prog_start = 1'b0;
        // Any access that is not the next unlock step drops the tracker
        if (reg_wr_en || reg_rd_en) begin
            ul_d = DEE_UL_IDLE;
            if (we && wsel == DEE_SEL_UNLOCK && wb == `DEE_UNLOCK_FIRST) begin
                ul_d = DEE_UL_GOT_FIRST;
            end
            if (we && wsel == DEE_SEL_UNLOCK && wb == `DEE_UNLOCK_SECOND &&
                ul_q == DEE_UL_GOT_FIRST) begin
                ul_d = DEE_UL_ARMED;
            end
        end
        if (we && wsel == DEE_SEL_ADDR) begin
            addr_d = wb;
        end
        if (we && wsel == DEE_SEL_DATA) begin
            data_d = wb;
        end
        if (rd_q) begin
            rd_d = 1'b0;
            if (!mss_q) begin
                data_d = arr_rdata;
            end
        end
        if (we && wsel == DEE_SEL_CTRL) begin
            mss_d = wb[`DEE_CTL_MSS];
            permit_d = wb[`DEE_CTL_PERMIT];
            if (wb[`DEE_CTL_RD] && !rd_q) begin
                rd_d = 1'b1;
            end
            // A start aimed at program memory is dropped at once
            if (wb[`DEE_CTL_WR] && !wr_q && permit_q && ul_q == DEE_UL_ARMED &&
                !wb[`DEE_CTL_MSS]) begin
                prog_start = 1'b1;
                wr_d = 1'b1;
            end
        end
        if (arr_done) begin
            wr_d = 1'b0;
        end
        if (we && wsel == DEE_SEL_STAT && wb[`DEE_STA_DONE]) begin
            done_d = 1'b0;
        end
        if (arr_done) begin
            done_d = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mss_q <= 1'b0;
            permit_q <= 1'b0;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            done_q <= 1'b0;
            data_q <= `DEE_RST_BYTE;
            addr_q <= `DEE_RST_BYTE;
            ul_q <= DEE_UL_IDLE;
        end else begin
            mss_q <= mss_d;
            permit_q <= permit_d;
            wr_q <= wr_d;
            rd_q <= rd_d;
            done_q <= done_d;
            data_q <= data_d;
            addr_q <= addr_d;
            ul_q <= ul_d;
        end
    end

    // ------------------------------------------------------------------------
    // Abort flag
    // ------------------------------------------------------------------------
    // Survives the ordinary reset so software can see the lost cycle afterwards
    always_comb begin
        abort_d = abort_q;
        if (we && wsel == DEE_SEL_CTRL) begin
            abort_d = wb[`DEE_CTL_ABORT];
        end
        if (!aresetn && arr_busy) begin
            abort_d = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!por_n) begin
            abort_q <= 1'b0;
        end else begin
            abort_q <= abort_d;
        end
    end

    // ------------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------------
    always_comb begin
        case (rsel)
            DEE_SEL_DATA: reg_rd_data = {24'h000000, data_q};
            DEE_SEL_ADDR: reg_rd_data = {24'h000000, addr_q};
            DEE_SEL_STAT: reg_rd_data = {31'h00000000, done_q};
            DEE_SEL_CTRL: reg_rd_data = {24'h000000, mss_q, 3'h0, abort_q, permit_q, wr_q, rd_q};
            default: reg_rd_data = 32'h00000000;
        endcase
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    sequence s_read_issue;
        rd_q && !mss_q;
    endsequence

    sequence s_ctrl_write;
        we && wsel == DEE_SEL_CTRL;
    endsequence

    sequence s_data_quiet;
        !rd_q && !(we && wsel == DEE_SEL_DATA);
    endsequence

    AST_READ_NEXT_CYCLE: assert property (@(posedge aclk) disable iff (!aresetn)
        s_read_issue |=> data_q == $past(arr_rdata))
        else $error("read byte not loaded in the next cycle");

    AST_READ_BIT_CLEARS: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_ctrl_write ##0 (wb[`DEE_CTL_RD] && !rd_q)) |=> rd_q ##1 !rd_q)
        else $error("read bit did not self-clear after one cycle");

    AST_DATA_HOLDS: assert property (@(posedge aclk) disable iff (!aresetn)
        s_data_quiet |=> $stable(data_q))
        else $error("data register changed without read or write");

    AST_PROG_MEM_READ_IDLE: assert property (@(posedge aclk) disable iff (!aresetn)
        (rd_q && mss_q && !(we && wsel == DEE_SEL_DATA)) |=> $stable(data_q))
        else $error("program memory read disturbed the data register");

    AST_START_NEEDS_UNLOCK: assert property (@(posedge aclk) disable iff (!aresetn)
        prog_start |-> ul_q == DEE_UL_ARMED ##1 arr_busy && wr_q)
        else $error("program cycle started without the unlock sequence");

    AST_START_NEEDS_PERMIT: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(wr_q) |-> $past(permit_q))
        else $error("start bit set while update permit was clear");

    AST_PERMIT_SOFTWARE_ONLY: assert property (@(posedge aclk) disable iff (!aresetn)
        !$stable(permit_q) |-> $past(we) && $past(wsel) == DEE_SEL_CTRL)
        else $error("update permit changed without a control write");

    AST_CYCLE_COMPLETES: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_q && !arr_done) |=> wr_q && arr_busy)
        else $error("program cycle ended before completion");

    AST_END_TOGETHER: assert property (@(posedge aclk) disable iff (!aresetn)
        arr_done |=> !wr_q && done_q && !arr_busy)
        else $error("start bit and done flag did not change together");

    AST_DONE_STICKY: assert property (@(posedge aclk) disable iff (!aresetn)
        (done_q && !(we && wsel == DEE_SEL_STAT && wb[`DEE_STA_DONE])) |=> done_q)
        else $error("done flag cleared without software");

    AST_ABORT_ON_RESET: assert property (@(posedge aclk) disable iff (!por_n)
        (!aresetn && arr_busy) |=> abort_q)
        else $error("abort flag not set by reset during programming");

    AST_TRACKER_RESTART: assert property (@(posedge aclk) disable iff (!aresetn)
        (reg_wr_en && !(we && wsel == DEE_SEL_UNLOCK)) |=> ul_q == DEE_UL_IDLE)
        else $error("unlock tracker kept state across another access");

endmodule // dee_top

`default_nettype wire

// [core/dee_consts.svh]
// Offsets, field positions, reset values and timing counts of the data byte store
`ifndef DEE_CONSTS_SVH
`define DEE_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define DEE_ADDR_W 12
`define DEE_OFS_DATA 12'h180
`define DEE_OFS_ADDR 12'h184
`define DEE_OFS_STAT 12'h188
`define DEE_OFS_CTRL 12'h18c
`define DEE_OFS_UNLOCK 12'h190

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define DEE_CTL_MSS 7
`define DEE_CTL_ABORT 3
`define DEE_CTL_PERMIT 2
`define DEE_CTL_WR 1
`define DEE_CTL_RD 0
`define DEE_STA_DONE 0

// ----------------------------------------------------------------------------
// Values
// ----------------------------------------------------------------------------
`define DEE_RST_BYTE 8'h00
`define DEE_UNLOCK_FIRST 8'h55
`define DEE_UNLOCK_SECOND 8'haa
`define DEE_RESP_OKAY 2'b00
`define DEE_RESP_SLVERR 2'b10
`define DEE_MEM_DEPTH 256

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define DEE_CLK_PERIOD_NS 10
`define DEE_PROG_TIME_NS 4000000
`define DEE_PROG_CYCLES ((`DEE_PROG_TIME_NS + `DEE_CLK_PERIOD_NS - 1) / `DEE_CLK_PERIOD_NS)
`define DEE_CNT_W 20

`endif

// [core/dee_pkg.sv]
// Types and register decoding shared by the data byte store
`default_nettype none
`include "dee_consts.svh"

package dee_pkg;

    typedef enum logic [2:0] {
        DEE_SEL_NONE,
        DEE_SEL_DATA,
        DEE_SEL_ADDR,
        DEE_SEL_STAT,
        DEE_SEL_CTRL,
        DEE_SEL_UNLOCK
    } dee_sel_t;

    typedef enum logic [1:0] {
        DEE_UL_IDLE,
        DEE_UL_GOT_FIRST,
        DEE_UL_ARMED
    } dee_unlock_t;

    typedef struct packed {
        logic [`DEE_ADDR_W-1:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } dee_reg_wr_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } dee_prog_req_t;

    function automatic dee_sel_t dee_decode(input logic [`DEE_ADDR_W-1:0] a);
        case (a)
            `DEE_OFS_DATA: dee_decode = DEE_SEL_DATA;
            `DEE_OFS_ADDR: dee_decode = DEE_SEL_ADDR;
            `DEE_OFS_STAT: dee_decode = DEE_SEL_STAT;
            `DEE_OFS_CTRL: dee_decode = DEE_SEL_CTRL;
            `DEE_OFS_UNLOCK: dee_decode = DEE_SEL_UNLOCK;
            default: dee_decode = DEE_SEL_NONE;
        endcase
    endfunction

endpackage : dee_pkg

`default_nettype wire

// [core/dee_axil_slave.sv]
// AXI4-Lite slave front end turning bus transfers into register strobes
`default_nettype none
`include "dee_consts.svh"

module dee_axil_slave
    import dee_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`DEE_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`DEE_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output dee_reg_wr_t reg_wr,
    output logic reg_wr_en,
    input wire logic reg_wr_err,
    output logic reg_rd_en,
    output logic [`DEE_ADDR_W-1:0] reg_rd_addr,
    input wire logic [31:0] reg_rd_data,
    input wire logic reg_rd_err
);

    logic aw_full_q, aw_full_d, w_full_q, w_full_d;
    logic [`DEE_ADDR_W-1:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;

    // Each address or data item parks until its partner arrives
    assign s_axi_awready = !aw_full_q;
    assign s_axi_wready = !w_full_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign reg_wr = '{addr: awaddr_q, data: wdata_q, strb: wstrb_q};
    assign reg_wr_en = aw_full_q && w_full_q && !bvalid_q;
    assign reg_rd_en = s_axi_arvalid && !rvalid_q;
    assign reg_rd_addr = s_axi_araddr;

    always_comb begin
        aw_full_d = aw_full_q;
        w_full_d = w_full_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (s_axi_awvalid && !aw_full_q) begin
            aw_full_d = 1'b1;
            awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_full_q) begin
            w_full_d = 1'b1;
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
        end
        if (reg_wr_en) begin
            aw_full_d = 1'b0;
            w_full_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = reg_wr_err ? `DEE_RESP_SLVERR : `DEE_RESP_OKAY;
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (reg_rd_en) begin
            rvalid_d = 1'b1;
            rdata_d = reg_rd_data;
            rresp_d = reg_rd_err ? `DEE_RESP_SLVERR : `DEE_RESP_OKAY;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
            bvalid_q <= 1'b0;
            bresp_q <= `DEE_RESP_OKAY;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= `DEE_RESP_OKAY;
        end else begin
            aw_full_q <= aw_full_d;
            w_full_q <= w_full_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

endmodule // dee_axil_slave

`default_nettype wire

// [core/dee_cell_array.sv]
// Byte store with asynchronous read and a timed program cycle
`default_nettype none
`include "dee_consts.svh"

module dee_cell_array
    import dee_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = `DEE_PROG_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic prog_start,
    input wire dee_prog_req_t prog_req,
    input wire logic [7:0] rd_addr,
    output logic [7:0] rd_data,
    output logic busy,
    output logic done
);

    logic [7:0] mem [`DEE_MEM_DEPTH];
    logic busy_q, busy_d;
    logic [`DEE_CNT_W-1:0] cnt_q, cnt_d;
    dee_prog_req_t req_q, req_d;

    assign rd_data = mem[rd_addr];
    assign busy = busy_q;
    assign done = busy_q && (cnt_q == '0);

    always_comb begin
        busy_d = busy_q;
        cnt_d = cnt_q;
        req_d = req_q;
        if (prog_start && !busy_q) begin
            busy_d = 1'b1;
            cnt_d = `DEE_CNT_W'(PROG_CYCLES - 1);
            req_d = prog_req;
        end else if (done) begin
            busy_d = 1'b0;
        end else if (busy_q) begin
            cnt_d = cnt_q - `DEE_CNT_W'(1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy_q <= 1'b0;
            cnt_q <= '0;
            req_q <= '0;
        end else begin
            busy_q <= busy_d;
            cnt_q <= cnt_d;
            req_q <= req_d;
        end
    end

    // Cell contents change only at the last count, so a reset mid-cycle leaves the old byte
    always_ff @(posedge aclk) begin
        if (aresetn && done) begin
            mem[req_q.addr] <= req_q.data;
        end
    end

endmodule // dee_cell_array

`default_nettype wire

// [testbench/dee_core_model.sv]
// Processor core model: issues register accesses over AXI4-Lite
`default_nettype none
`include "dee_consts.svh"

module dee_core_model (
    input wire logic aclk,
    output var logic [`DEE_ADDR_W-1:0] s_axi_awaddr,
    output var logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output var logic [31:0] s_axi_wdata,
    output var logic [3:0] s_axi_wstrb,
    output var logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output var logic s_axi_bready,
    output var logic [`DEE_ADDR_W-1:0] s_axi_araddr,
    output var logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output var logic s_axi_rready
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        s_axi_awaddr = '0;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = '0;
        s_axi_wstrb = 4'h0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = '0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
    end

    // Released payload is inverted so a stale value never looks valid
    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw;
        logic w;
        aw = 1'b1;
        w = 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (aw && s_axi_awready) begin
                aw = 1'b0;
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~a;
            end
            if (w && s_axi_wready) begin
                w = 1'b0;
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~d;
            end
            if (s_axi_bvalid) break;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar;
        ar = 1'b1;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (ar && s_axi_arready) begin
                ar = 1'b0;
                s_axi_arvalid <= 1'b0;
                s_axi_araddr <= ~a;
            end
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
endmodule // dee_core_model

`default_nettype wire

// [testbench/data_eeprom_access_control_tb.sv]
// Self-checking bench for the data byte store access control
`default_nettype none
`include "dee_consts.svh"

module data_eeprom_access_control_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic aclk, aresetn, por_n;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int miscompares = 0;
    int total_checks = 0;
    logic [11:0] ta [4] = '{`DEE_OFS_DATA, `DEE_OFS_ADDR, `DEE_OFS_UNLOCK, 12'h1f0};
    logic [31:0] td [4] = '{32'hffff_ffa5, 32'h0000_003c, 32'h0000_0055, 32'h0000_0077};
    logic [31:0] te [4] = '{32'h0000_00a5, 32'h0000_003c, 32'h0000_0000, 32'h0000_0000};
    logic [1:0] tr [4] = '{`DEE_RESP_OKAY, `DEE_RESP_OKAY, `DEE_RESP_OKAY, `DEE_RESP_SLVERR};

    dee_top #(.PROG_CYCLES(16)) DUT (.aclk, .aresetn, .por_n, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    dee_core_model u_core (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic w(input logic [11:0] a, input logic [7:0] d);
        logic [1:0] r;
        u_core.wr(a, {24'h0, d}, r);
    endtask

    task automatic rc(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        logic [1:0] r;
        u_core.rd(a, q, r);
        check(q, e);
    endtask

    // Unlock and start; a nonzero gap puts a stray read inside the sequence
    task automatic unlock_start(input logic [7:0] k1, input logic [7:0] k2, input bit gap);
        w(`DEE_OFS_UNLOCK, k1);
        if (gap) rc(`DEE_OFS_DATA, 32'h0000_00a5);
        w(`DEE_OFS_UNLOCK, k2);
        w(`DEE_OFS_CTRL, 8'h06);
    endtask

    task automatic end_sim;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        #200000;
        miscompares++;
        end_sim();
    end

    initial begin
        logic [31:0] q;
        logic [1:0] r;
        aresetn = 1'b0;
        por_n = 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        por_n <= 1'b1;
        @(posedge aclk);
        rc(`DEE_OFS_CTRL, 32'h0);
        rc(`DEE_OFS_STAT, 32'h0);
        for (int i = 0; i < 4; i++) begin
            u_core.wr(ta[i], td[i], r);
            check({30'h0, r}, {30'h0, tr[i]});
            u_core.rd(ta[i], q, r);
            check(q, te[i]);
            check({30'h0, r}, {30'h0, tr[i]});
        end
        // Failed starts: no permit, wrong order, stray access
        unlock_start(8'h55, 8'haa, 1'b0);
        rc(`DEE_OFS_CTRL, 32'h04);
        w(`DEE_OFS_CTRL, 8'h04);
        unlock_start(8'haa, 8'h55, 1'b0);
        rc(`DEE_OFS_CTRL, 32'h04);
        unlock_start(8'h55, 8'haa, 1'b1);
        rc(`DEE_OFS_CTRL, 32'h04);
        // Good program cycle with permit dropped meanwhile
        w(`DEE_OFS_ADDR, 8'h10);
        w(`DEE_OFS_DATA, 8'h5a);
        unlock_start(8'h55, 8'haa, 1'b0);
        rc(`DEE_OFS_CTRL, 32'h06);
        w(`DEE_OFS_CTRL, 8'h00);
        rc(`DEE_OFS_CTRL, 32'h02);
        repeat (40) begin
            u_core.rd(`DEE_OFS_CTRL, q, r);
            if (q[1] === 1'b0) break;
        end
        check(q, 32'h0);
        rc(`DEE_OFS_STAT, 32'h01);
        w(`DEE_OFS_DATA, 8'h00);
        w(`DEE_OFS_CTRL, 8'h81);
        rc(`DEE_OFS_DATA, 32'h0);
        w(`DEE_OFS_CTRL, 8'h01);
        rc(`DEE_OFS_CTRL, 32'h0);
        rc(`DEE_OFS_DATA, 32'h5a);
        rc(`DEE_OFS_DATA, 32'h5a);
        rc(`DEE_OFS_STAT, 32'h01);
        w(`DEE_OFS_STAT, 8'h01);
        rc(`DEE_OFS_STAT, 32'h0);
        // Reset in mid-cycle leaves the abort flag up until power-on reset
        w(`DEE_OFS_CTRL, 8'h04);
        unlock_start(8'h55, 8'haa, 1'b0);
        rc(`DEE_OFS_CTRL, 32'h06);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rc(`DEE_OFS_CTRL, 32'h08);
        rc(`DEE_OFS_STAT, 32'h0);
        por_n <= 1'b0;
        repeat (2) @(posedge aclk);
        por_n <= 1'b1;
        @(posedge aclk);
        rc(`DEE_OFS_CTRL, 32'h0);
        w(`DEE_OFS_CTRL, 8'h08);
        rc(`DEE_OFS_CTRL, 32'h08);
        end_sim();
    end
endmodule // data_eeprom_access_control_tb

`default_nettype wire
